// [ipc_device.sv]
`timescale 1ns/1ps
module ipc_device #(
   parameter logic [6:0] SLAVE_ADDR = ipc_pkg::SLAVE_ADDR_DEF
) (
   // clock and reset
   input  wire logic                        i_clk,
   input  wire logic                        i_reset,
   // serial bus and alert line
   ipc_if.device                            bus,
   // port pins
   input  wire logic [ipc_pkg::PORT_W-1:0]  i_port,
   output logic      [ipc_pkg::PORT_W-1:0]  o_port,
   output logic      [ipc_pkg::PORT_W-1:0]  o_port_oe
);
   import ipc_pkg::*;

   // ----------------------------------------------------------------
   // synchronisers and bus event decode
   // ----------------------------------------------------------------
   logic [1:0]        bus_s;
   logic [PORT_W-1:0] pins_s;
   logic              scl_q;
   logic              sda_q;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_ev;
   logic              stop_ev;

   // scl and sda go through one synchroniser so their order survives
   ipc_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_d     ({bus.scl, bus.sda}),
      .o_q     (bus_s)
   );

   ipc_sync #(.WIDTH(PORT_W), .INIT(PORT_RESET)) u_pin_sync (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_d     (i_port),
      .o_q     (pins_s)
   );

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= bus_s[1];
         sda_q <= bus_s[0];
      end
   end

   assign scl_rise = bus_s[1] & ~scl_q;
   assign scl_fall = ~bus_s[1] & scl_q;
   assign start_ev = bus_s[1] & scl_q & sda_q & ~bus_s[0];
   assign stop_ev  = bus_s[1] & scl_q & ~sda_q & bus_s[0];

   // ----------------------------------------------------------------
   // slave protocol engine
   // ----------------------------------------------------------------
   ipc_dev_state_t state_q;
   logic [3:0]     bit_q;
   logic [7:0]     shift_q;
   logic           rw_q;
   logic           macked_q;
   logic           sda_oe_q;
   logic           wr_apply;
   logic           rd_load;

   assign wr_apply = (state_q == D_WR_ACK) & scl_rise;
   assign rd_load  = scl_rise & (((state_q == D_ADDR_ACK) & rw_q) | ((state_q == D_RD_ACK) & ~bus_s[0]));

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_q  <= D_IDLE;
         bit_q    <= 4'h0;
         shift_q  <= 8'h00;
         rw_q     <= 1'b0;
         macked_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (start_ev) begin
         state_q  <= D_ADDR;
         bit_q    <= 4'h0;
         sda_oe_q <= 1'b0;
      end else if (stop_ev) begin
         state_q  <= D_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         case (state_q)
            D_IDLE: begin
               sda_oe_q <= 1'b0;
            end
            D_ADDR, D_WR_DATA: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], bus_s[0]};
                  bit_q   <= bit_q + 4'h1;
               end else if (scl_fall && bit_q == BYTE_BITS) begin
                  if (state_q == D_WR_DATA) begin
                     sda_oe_q <= 1'b1;
                     state_q  <= D_WR_ACK;
                  end else if (shift_q[7:1] == SLAVE_ADDR) begin
                     sda_oe_q <= 1'b1;
                     rw_q     <= shift_q[0];
                     state_q  <= D_ADDR_ACK;
                  end else begin
                     state_q  <= D_IDLE;
                  end
               end
            end
            D_ADDR_ACK: begin
               if (rd_load) begin
                  shift_q <= pins_s;
               end else if (scl_fall) begin
                  bit_q <= 4'h0;
                  if (rw_q) begin
                     sda_oe_q <= ~shift_q[7];
                     state_q  <= D_RD_DATA;
                  end else begin
                     sda_oe_q <= 1'b0;
                     state_q  <= D_WR_DATA;
                  end
               end
            end
            D_WR_ACK: begin
               // ack held low across the whole high phase
               if (scl_fall) begin
                  sda_oe_q <= 1'b0;
                  bit_q    <= 4'h0;
                  state_q  <= D_WR_DATA;
               end
            end
            D_RD_DATA: begin
               if (scl_rise) begin
                  bit_q <= bit_q + 4'h1;
               end else if (scl_fall) begin
                  if (bit_q == BYTE_BITS) begin
                     sda_oe_q <= 1'b0;
                     state_q  <= D_RD_ACK;
                  end else begin
                     sda_oe_q <= ~shift_q[6];
                     shift_q  <= {shift_q[6:0], 1'b0};
                  end
               end
            end
            D_RD_ACK: begin
               if (scl_rise) begin
                  macked_q <= ~bus_s[0];
                  if (rd_load) begin
                     shift_q <= pins_s;
                  end
               end else if (scl_fall) begin
                  bit_q <= 4'h0;
                  if (macked_q) begin
                     sda_oe_q <= ~shift_q[7];
                     state_q  <= D_RD_DATA;
                  end else begin
                     // nack ends the read; line stays free for stop
                     sda_oe_q <= 1'b0;
                     state_q  <= D_IDLE;
                  end
               end
            end
            default: begin
               state_q  <= D_IDLE;
               sda_oe_q <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // port latch and quasi-bidirectional drive
   // ----------------------------------------------------------------
   logic [PORT_W-1:0] latch_q;
   logic [PORT_W-1:0] port_oe_q;
   logic              pulse_q;

   // pulse_q is the write pulse: high half of the data ack clock
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         latch_q   <= PORT_RESET;
         port_oe_q <= '0;
         pulse_q   <= 1'b0;
      end else if (wr_apply) begin
         latch_q   <= shift_q;
         port_oe_q <= '1;
         pulse_q   <= 1'b1;
      end else if (pulse_q && (scl_fall || start_ev || stop_ev)) begin
         port_oe_q <= ~latch_q;
         pulse_q   <= 1'b0;
      end
   end

   assign o_port    = latch_q;
   assign o_port_oe = port_oe_q;

   // ----------------------------------------------------------------
   // change alert
   // ----------------------------------------------------------------
   logic [PORT_W-1:0] ref_q;
   logic              alert_q;
   logic              ref_take;

   // retaking at the pulse end picks up the levels just driven out
   assign ref_take = rd_load | wr_apply | (pulse_q & scl_fall);

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ref_q <= PORT_RESET;
      end else if (ref_take) begin
         ref_q <= pins_s;
      end
   end

   // a pin moving in the capture cycle may be folded into the reference
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         alert_q <= 1'b0;
      end else if (ref_take || pulse_q) begin
         alert_q <= 1'b0;
      end else begin
         alert_q <= (pins_s != ref_q);
      end
   end

   // ----------------------------------------------------------------
   // open-drain outputs
   // ----------------------------------------------------------------
   assign bus.d_sda_o  = 1'b0;
   assign bus.d_sda_oe = sda_oe_q;
   assign bus.d_int_o  = 1'b0;
   assign bus.d_int_oe = alert_q;
endmodule : ipc_device

// [ipc_pkg.sv]
package ipc_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCL_PERIOD_NS = 1600;
   // scl is built from four quarter phases of this many clocks
   localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // framing and reset values
   // ----------------------------------------------------------------
   localparam int              PORT_W         = 8;
   localparam logic [3:0]      BYTE_BITS      = 4'h8;
   localparam logic [7:0]      PORT_RESET     = 8'hff;
   localparam logic [6:0]      SLAVE_ADDR_DEF = 7'h20;
   localparam logic [3:0]      COUNT_ONE      = 4'h1;
   localparam logic [1:0]      QTR_LAST       = 2'h3;

   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      D_IDLE, D_ADDR, D_ADDR_ACK, D_WR_DATA, D_WR_ACK, D_RD_DATA, D_RD_ACK
   } ipc_dev_state_t;

   typedef enum logic [1:0] {
      M_IDLE, M_START, M_BIT, M_STOP
   } ipc_mst_state_t;
endpackage : ipc_pkg

// [ipc_if.sv]
`timescale 1ns/1ps
interface ipc_if;
   // ----------------------------------------------------------------
   // driver side of each open-drain line
   // ----------------------------------------------------------------
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic d_int_o;
   logic d_int_oe;

   // ----------------------------------------------------------------
   // wired-and line levels, pulled high when nobody sinks
   // ----------------------------------------------------------------
   logic scl;
   logic sda;
   logic int_n;

   assign scl   = !(m_scl_oe && !m_scl_o);
   assign sda   = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));
   assign int_n = !(d_int_oe && !d_int_o);

   modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda, int_n);
   modport device (output d_sda_o, d_sda_oe, d_int_o, d_int_oe, input scl, sda);
endinterface : ipc_if

// [ipc_sync.sv]
`timescale 1ns/1ps
module ipc_sync #(
   parameter int                WIDTH = 1,
   parameter logic [WIDTH-1:0]  INIT  = '1
) (
   // clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] i_d,
   output logic      [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta_q;

   // meta_q feeds only the second stage
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         meta_q <= INIT;
         o_q    <= INIT;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule : ipc_sync

// [ipc_master.sv]
`timescale 1ns/1ps
module ipc_master #(
   parameter logic [6:0] SLAVE_ADDR = ipc_pkg::SLAVE_ADDR_DEF
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   // serial bus and alert line
   ipc_if.master            bus,
   // transfer request
   input  wire logic        i_req,
   input  wire logic        i_rw,
   input  wire logic [3:0]  i_count,
   input  wire logic [7:0]  i_wdata,
   // transfer status
   output logic             o_busy,
   output logic             o_done,
   output logic             o_nack,
   output logic [7:0]       o_rdata,
   output logic             o_rvalid,
   output logic             o_alert
);
   import ipc_pkg::*;

   // ----------------------------------------------------------------
   // synchronisers and quarter-phase divider
   // ----------------------------------------------------------------
   logic [2:0] in_s;
   logic [7:0] div_q;
   logic       tick;

   ipc_sync #(.WIDTH(3), .INIT(3'h7)) u_sync (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_d     ({bus.scl, bus.sda, bus.int_n}),
      .o_q     (in_s)
   );

   ipc_mst_state_t state_q;

   assign tick = (div_q == 8'(SCL_QTR_CYC - 1));

   always_ff @(posedge i_clk) begin
      if (i_reset || state_q == M_IDLE || tick) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // bit sequencer
   // ----------------------------------------------------------------
   logic [1:0] q_q;
   logic [3:0] bit_q;
   logic [3:0] left_q;
   logic [7:0] shift_q;
   logic [7:0] wdata_q;
   logic       addr_q;
   logic       rw_q;
   logic       scl_oe_q;
   logic       sda_oe_q;
   logic       tx;

   assign tx = addr_q | ~rw_q;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_q  <= M_IDLE;
         q_q      <= 2'h0;
         bit_q    <= 4'h0;
         left_q   <= 4'h0;
         shift_q  <= 8'h00;
         wdata_q  <= 8'h00;
         addr_q   <= 1'b0;
         rw_q     <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         o_nack   <= 1'b0;
         o_rdata  <= 8'h00;
         o_rvalid <= 1'b0;
         o_done   <= 1'b0;
      end else begin
         o_rvalid <= 1'b0;
         o_done   <= 1'b0;
         if (state_q == M_IDLE) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            q_q      <= 2'h0;
            if (i_req && in_s[2] && in_s[1]) begin
               rw_q    <= i_rw;
               left_q  <= (i_rw && i_count == 4'h0) ? COUNT_ONE : i_count;
               shift_q <= {SLAVE_ADDR, i_rw};
               wdata_q <= i_wdata;
               addr_q  <= 1'b1;
               bit_q   <= 4'h0;
               o_nack  <= 1'b0;
               state_q <= M_START;
            end
         end else if (tick) begin
            q_q <= q_q + 2'h1;
            case (state_q)
               M_START: begin
                  // sda falls a quarter before scl does
                  if (q_q == 2'h0) sda_oe_q <= 1'b1;
                  if (q_q == 2'h1) begin
                     scl_oe_q <= 1'b1;
                     q_q      <= 2'h0;
                     state_q  <= M_BIT;
                  end
               end
               M_BIT: begin
                  case (q_q)
                     2'h0: begin
                        if (bit_q < BYTE_BITS) begin
                           sda_oe_q <= tx & ~shift_q[7];
                        end else begin
                           sda_oe_q <= ~tx & (left_q != COUNT_ONE);
                        end
                     end
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: begin
                        if (bit_q < BYTE_BITS && !tx) begin
                           shift_q <= {shift_q[6:0], in_s[1]};
                        end else if (bit_q == BYTE_BITS && tx) begin
                           o_nack <= in_s[1];
                        end
                     end
                     default: begin
                        scl_oe_q <= 1'b1;
                        if (bit_q < BYTE_BITS) begin
                           bit_q <= bit_q + 4'h1;
                           if (tx) shift_q <= {shift_q[6:0], 1'b0};
                        end else begin
                           // byte closed by its acknowledge slot
                           bit_q   <= 4'h0;
                           shift_q <= wdata_q;
                           addr_q  <= 1'b0;
                           if (!addr_q) left_q <= left_q - 4'h1;
                           if (!tx) begin
                              o_rdata  <= shift_q;
                              o_rvalid <= 1'b1;
                           end
                           if (o_nack || (addr_q ? left_q == 4'h0 : left_q == COUNT_ONE)) begin
                              state_q <= M_STOP;
                           end
                        end
                     end
                  endcase
               end
               M_STOP: begin
                  case (q_q)
                     2'h0: sda_oe_q <= 1'b1;
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: sda_oe_q <= 1'b0;
                     default: begin
                        o_done  <= 1'b1;
                        state_q <= M_IDLE;
                     end
                  endcase
               end
               default: state_q <= M_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign bus.m_scl_o  = 1'b0;
   assign bus.m_scl_oe = scl_oe_q;
   assign bus.m_sda_o  = 1'b0;
   assign bus.m_sda_oe = sda_oe_q;
   assign o_busy       = (state_q != M_IDLE);
   assign o_alert      = ~in_s[0];
endmodule : ipc_master

// [ipc_chk.sv]
`timescale 1ns/1ps
module ipc_chk (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // device drivers
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic d_int_o,
   input wire logic d_int_oe,
   // resolved lines
   input wire logic scl,
   input wire logic sda
);
   // ---------------------------------------------------------------
   // bus decode, seen the way any listener on the wire would
   // ---------------------------------------------------------------
   logic       scl_q;
   logic       sda_q;
   logic [3:0] bit_q;
   logic       first_q;
   logic       rd_q;
   logic       start_ev;
   logic       stop_ev;
   logic       ack_rise;

   assign start_ev = scl && scl_q && sda_q && !sda;
   assign stop_ev  = scl && scl_q && !sda_q && sda;
   assign ack_rise = scl && !scl_q && (bit_q == 4'h8);

   always_ff @(posedge i_clk) begin
      scl_q <= scl;
      sda_q <= sda;
   end

   // bit 9 of each byte is the acknowledge slot
   always_ff @(posedge i_clk) begin
      if (i_reset || start_ev) begin
         bit_q   <= 4'h0;
         first_q <= 1'b1;
         rd_q    <= 1'b0;
      end else if (scl && !scl_q) begin
         bit_q <= (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
         if (bit_q == 4'h9) begin
            first_q <= 1'b0;
         end
         if (first_q && bit_q == 4'h7) begin
            rd_q <= sda;
         end
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   open_drain_a: assert property (!d_sda_o && !d_int_o)
      else $error("device drives a line high");
   sda_stable_a: assert property ($changed(d_sda_oe) |-> !scl && !scl_q)
      else $error("device moved sda while scl high");
   ack_hold_a: assert property ($rose(scl) && d_sda_oe |-> d_sda_oe [*8])
      else $error("device low level not held through scl high");
   scl_pulse_a: assert property ($rose(scl) |-> scl [*8])
      else $error("scl high phase too short");
   idle_release_a: assert property (stop_ev |-> !d_sda_oe [*8])
      else $error("device drives sda after stop");
   dev_ack_a: assert property (ack_rise && (first_q || !rd_q) |-> d_sda_oe)
      else $error("device did not acknowledge");
   alert_clear_a: assert property (ack_rise && d_sda_oe && (first_q == rd_q) |-> ##[1:6] !d_int_oe)
      else $error("alert not released by transfer");
   nack_release_a: assert property (ack_rise && !first_q && rd_q && sda |-> !d_sda_oe [*8] ##1 !d_sda_oe [*8])
      else $error("device holds sda after final nack");
   rd_clear_a: assert property (ack_rise && !first_q && rd_q && !sda |-> ##[1:6] !d_int_oe)
      else $error("alert not released by port read");
endmodule : ipc_chk

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
   import ipc_pkg::*;
   // ---------------------------------------------------------------
   // stimulus and model state
   // ---------------------------------------------------------------
   logic        i_clk      = 1'b0;
   logic        i_reset;
   logic        req;
   logic        rw;
   logic [3:0]  count;
   logic [7:0]  wdata;
   logic [7:0]  ext;
   logic [7:0]  prev_ext;
   logic [7:0]  pins;
   logic [7:0]  port_o;
   logic [7:0]  port_oe;
   logic        busy;
   logic        done;
   logic        nack;
   logic        rvalid;
   logic        alert;
   logic [7:0]  rdata;
   logic [31:0] lfsr;
   int          err_count  = 0;
   int          num_checks = 0;
   int          cycles     = 0;
   int          latch_m    = 32'hff;
   int          ref_m      = 32'hff;
   logic [7:0]  exp_q[$];

   // external drivers win over the weak pull-up and the brief strong one
   assign pins = ext & (~port_oe | port_o);

   ipc_if ipc_if_inst ();
   ipc_master ipc_master_inst (.i_clk(i_clk), .i_reset(i_reset), .bus(ipc_if_inst), .i_req(req), .i_rw(rw),
      .i_count(count), .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_nack(nack), .o_rdata(rdata),
      .o_rvalid(rvalid), .o_alert(alert));
   ipc_device ipc_device_inst (.i_clk(i_clk), .i_reset(i_reset), .bus(ipc_if_inst), .i_port(pins),
      .o_port(port_o), .o_port_oe(port_oe));
   ipc_chk ipc_chk_inst (.i_clk(i_clk), .i_reset(i_reset), .d_sda_o(ipc_if_inst.d_sda_o),
      .d_sda_oe(ipc_if_inst.d_sda_oe), .d_int_o(ipc_if_inst.d_int_o), .d_int_oe(ipc_if_inst.d_int_oe),
      .scl(ipc_if_inst.scl), .sda(ipc_if_inst.sda));

   always #50 i_clk = ~i_clk;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic final_report;
      if (err_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t byte %h expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk1

   // input bits 1:0 are always written high so outside drivers keep control
   task automatic xfer(input logic r, input logic [3:0] n);
      logic [7:0] w;
      // bits 7:6 form one tied sink pair, so they always switch together
      w = {lfsr[7], lfsr[7:3], 2'b11};
      if (r) begin
         // a read count of zero still fetches one byte
         repeat ((n == 4'h0) ? 4'h1 : n) exp_q.push_back(ext & latch_m[7:0]);
      end else if (n != 4'h0) begin
         latch_m = int'(w);
      end
      @(posedge i_clk);
      rw    <= r;
      count <= n;
      wdata <= w;
      req   <= 1'b1;
      while (busy !== 1'b1) @(negedge i_clk);
      @(posedge i_clk);
      req <= 1'b0;
      while (done !== 1'b1) begin
         @(negedge i_clk);
         if (rvalid === 1'b1) chk8(rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
      end
      chk1(nack, 1'b0);
      chk1(busy, 1'b0);
      chk1(exp_q.size() == 0, 1'b1);
      if (!r) begin
         chk8(port_o, latch_m[7:0]);
         chk8(port_oe, ~latch_m[7:0]);
         chk8(port_o & port_oe, 8'h00);
         chk8(pins, ext & latch_m[7:0]);
      end
      // an address-only write touches neither the port nor its reference
      if (r || n != 4'h0) ref_m = int'(ext & latch_m[7:0]);
      repeat (10) @(negedge i_clk);
      chk1(alert, (ext & latch_m[7:0]) != ref_m[7:0]);
   endtask : xfer

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 12000) begin
         err_count++;
         final_report();
      end
   end

   initial begin
      i_reset = 1'b1;
      req     = 1'b0;
      rw      = 1'b0;
      count   = 4'h1;
      wdata   = 8'hff;
      ext     = 8'hfe;
      lfsr    = 32'hb012;
      repeat (4) @(posedge i_clk);
      i_reset <= 1'b0;
      repeat (10) @(negedge i_clk);
      chk1(alert, 1'b1);
      for (int it = 0; it < 10; it++) begin
         xfer(it[0], 4'(it % 3));
         prev_ext = ext;
         lfsr = lfsr_next(lfsr);
         @(posedge i_clk);
         ext <= {6'h3f, lfsr[1:0]};
         repeat (10) @(negedge i_clk);
         chk1(alert, (ext & latch_m[7:0]) != ref_m[7:0]);
         if (it % 3 == 2) begin
            @(posedge i_clk);
            ext <= prev_ext;
            repeat (10) @(negedge i_clk);
            chk1(alert, 1'b0);
         end
      end
      final_report();
   end
endmodule : testbench
